//--- logic/ssp_pkg.sv
// Shared constants and types for the synchronous serial port
// Assumes a single 10 MHz system clock with a synchronous active-high reset
package ssp_pkg;

    // Byte width of the transfer path
    localparam int SSP_DATA_W = 8;

    // Master bit-rate selections
    localparam logic [2:0] SSP_RATE_DIV4 = 3'h0;
    localparam logic [2:0] SSP_RATE_DIV16 = 3'h1;
    localparam logic [2:0] SSP_RATE_DIV64 = 3'h2;
    localparam logic [2:0] SSP_RATE_TMR2 = 3'h3;
    localparam logic [2:0] SSP_RATE_BAUD = 3'h4;

    // System clocks per half serial-clock period for the fixed rates
    localparam logic [9:0] SSP_HALF_DIV4 = 10'h002;
    localparam logic [9:0] SSP_HALF_DIV16 = 10'h008;
    localparam logic [9:0] SSP_HALF_DIV64 = 10'h020;
    localparam logic [9:0] SSP_HALF_BAUD_STEP = 10'h002;

    // Serial clock edges in one master byte, and bits in one bus byte
    localparam logic [4:0] SSP_SPI_EDGES = 5'h10;
    localparam logic [3:0] SSP_I2C_BITS = 4'h8;

    // Reset values
    localparam logic [7:0] SSP_BUF_RST = 8'h00;
    localparam logic SSP_RW_RST = 1'b0;

    // Bus slave receive sequence
    typedef enum logic [2:0] {
        SSP_I2C_IDLE,
        SSP_I2C_ADDR,
        SSP_I2C_DATA,
        SSP_I2C_ACK,
        SSP_I2C_SKIP
    } ssp_i2c_state_e;

endpackage : ssp_pkg

//--- logic/ssp_edge_det.sv
// Level tracker with rise and fall detection for one input line
// Assumes the line is already synchronous to the clock
`timescale 1ns/1ps
module ssp_edge_det (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // Line
    input wire logic i_line,
    // Detected events
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);
    logic prev_reg;
    logic prev_next;

    always_comb begin
        prev_next = i_line;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            prev_reg <= 1'b1;
        end else begin
            prev_reg <= prev_next;
        end
    end

    assign o_level = prev_reg;
    assign o_rise = i_line & ~prev_reg;
    assign o_fall = ~i_line & prev_reg;

endmodule : ssp_edge_det

//--- logic/ssp_rate_gen.sv
// Half-period tick generator for the master serial clock
// Assumes i_timer2_tick is a one-cycle pulse from an external timer
`timescale 1ns/1ps
module ssp_rate_gen
    import ssp_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // Control
    input wire logic i_run,
    input wire logic [2:0] i_rate_sel,
    input wire logic [7:0] i_baud_reload,
    input wire logic i_timer2_tick,
    // Half-period enable pulse
    output logic o_tick
);
    logic [9:0] cnt_reg;
    logic [9:0] cnt_next;
    logic [9:0] half;

    always_comb begin
        case (i_rate_sel)
            SSP_RATE_DIV4: half = SSP_HALF_DIV4;
            SSP_RATE_DIV16: half = SSP_HALF_DIV16;
            SSP_RATE_DIV64: half = SSP_HALF_DIV64;
            // Fosc / (4 * (reload + 1)) gives 2 * (reload + 1) clocks per half period
            SSP_RATE_BAUD: half = 10'({1'b0, i_baud_reload, 1'b0} + SSP_HALF_BAUD_STEP);
            default: half = SSP_HALF_DIV4;
        endcase
        if (i_rate_sel == SSP_RATE_TMR2) begin
            // Serial clock toggles once per timer tick, so its rate is the timer output halved
            o_tick = i_run & i_timer2_tick;
        end else begin
            o_tick = i_run && (cnt_reg == 10'(half - 10'h001));
        end
        if (!i_run || o_tick) begin
            cnt_next = 10'h000;
        end else begin
            cnt_next = 10'(cnt_reg + 10'h001);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            cnt_reg <= 10'h000;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

endmodule : ssp_rate_gen

//--- logic/ssp_serial_port.sv
// Synchronous serial port: byte-wide master for clocked serial links and
// receive-only two-wire bus slave with 7-bit addressing
// Assumes all pins are synchronous to i_ref_clk and the serial clock pin
// readback is looped to i_sck_in by the pin selection logic
`timescale 1ns/1ps
module ssp_serial_port
    import ssp_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // Mode and configuration
    input wire logic i_enable,
    input wire logic i_mode_i2c,
    input wire logic i_clk_polarity_release,
    input wire logic i_clk_edge_sel,
    input wire logic i_sample_phase,
    input wire logic [2:0] i_rate_sel,
    input wire logic [7:0] i_baud_reload,
    input wire logic i_timer2_tick,
    input wire logic i_sdo_disable,
    input wire logic [6:0] i_slave_addr,
    input wire logic i_stretch_enable,
    input wire logic i_buffer_overwrite_en,
    input wire logic i_start_irq_en,
    // Software access
    input wire logic i_buf_wr,
    input wire logic [7:0] i_buf_wdata,
    input wire logic i_buf_rd,
    input wire logic i_clk_release_set,
    input wire logic i_overflow_clr,
    input wire logic i_irq_flag_clr,
    // Status
    output logic [7:0] o_xfer_buffer,
    output logic o_buffer_full,
    output logic o_rx_overflow,
    output logic o_port_irq_flag,
    output logic o_start_seen,
    output logic o_stop_seen,
    output logic o_rw_status,
    output logic o_spi_busy,
    output logic o_clk_held,
    // Master serial pins
    output logic o_sck,
    output logic o_sck_oe,
    input wire logic i_sck_in,
    output logic o_sdo,
    output logic o_sdo_oe,
    input wire logic i_sdi,
    // Two-wire bus pins, open drain
    input wire logic i_scl,
    output logic o_scl_out,
    output logic o_scl_oe,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    output logic o_pin_override
);
    logic spi_mode, i2c_active, tick;
    // Master shift state
    logic spi_busy_reg, spi_busy_next, sck_reg, sck_next, sdo_reg, sdo_next, pend_reg, pend_next;
    logic [4:0] tgl_cnt_reg, tgl_cnt_next, edge_cnt_reg, edge_cnt_next;
    logic [7:0] tx_sr_reg, tx_sr_next, shift_reg, shift_next;
    logic spi_done, sck_rise, sck_fall, sck_edge, lead_edge, out_edge;
    // Bus slave state
    ssp_i2c_state_e i2c_st_reg, i2c_st_next;
    logic [3:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] i2c_sr_reg, i2c_sr_next;
    logic sda_oe_reg, sda_oe_next, hold_reg, hold_next, scl_level, scl_rise, scl_fall, sda_rise, sda_fall;
    logic start_ev, stop_ev, i2c_accept, i2c_ovf, hold_set, rw_load, match, room;
    // Flags and buffer
    logic [7:0] buf_reg, buf_next;
    logic bf_reg, bf_next, ov_reg, ov_next, irq_reg, irq_next, start_reg, start_next;
    logic stop_reg, stop_next, rw_reg, rw_next, ov_set, irq_set;

    assign spi_mode = i_enable & ~i_mode_i2c;
    assign i2c_active = i_enable & i_mode_i2c;

    ssp_rate_gen u_rate (
        .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_run(spi_busy_reg), .i_rate_sel(i_rate_sel),
        .i_baud_reload(i_baud_reload), .i_timer2_tick(i_timer2_tick), .o_tick(tick)
    );
    ssp_edge_det u_sck_edge (
        .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_line(i_sck_in), .o_level(), .o_rise(sck_rise), .o_fall(sck_fall)
    );
    ssp_edge_det u_scl_edge (
        .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_line(i_scl), .o_level(scl_level), .o_rise(scl_rise), .o_fall(scl_fall)
    );
    ssp_edge_det u_sda_edge (
        .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_line(i_sda), .o_level(), .o_rise(sda_rise), .o_fall(sda_fall)
    );

    // Shift logic follows the clock seen on the pin; a polarity settle before the first toggle is no edge
    assign sck_edge = spi_busy_reg & (tgl_cnt_reg != 5'h00) & (sck_rise | sck_fall);
    assign lead_edge = i_clk_polarity_release ? sck_fall : sck_rise;
    // Edge select set: data changes on trailing edges, first bit presented at load
    assign out_edge = i_clk_edge_sel ? ~lead_edge : lead_edge;

    always_comb begin
        spi_busy_next = spi_busy_reg;
        sck_next = sck_reg;
        tgl_cnt_next = tgl_cnt_reg;
        edge_cnt_next = edge_cnt_reg;
        tx_sr_next = tx_sr_reg;
        sdo_next = sdo_reg;
        shift_next = shift_reg;
        pend_next = pend_reg;
        spi_done = 1'b0;
        if (!spi_mode) begin
            spi_busy_next = 1'b0;
            sck_next = i_clk_polarity_release;
            pend_next = 1'b0;
        end else if (!spi_busy_reg) begin
            sck_next = i_clk_polarity_release;
            if (i_buf_wr) begin
                // No handshake with the far end: a write always starts at once
                spi_busy_next = 1'b1;
                tgl_cnt_next = 5'h00;
                edge_cnt_next = 5'h00;
                pend_next = 1'b0;
                if (i_clk_edge_sel) begin
                    sdo_next = i_buf_wdata[7];
                    tx_sr_next = {i_buf_wdata[6:0], 1'b0};
                end else begin
                    tx_sr_next = i_buf_wdata;
                end
            end
        end else begin
            if (tick && (tgl_cnt_reg < SSP_SPI_EDGES)) begin
                sck_next = ~sck_reg;
                tgl_cnt_next = 5'(tgl_cnt_reg + 5'h01);
            end
            // Late sampling phase takes the input half a period after the edge
            if (pend_reg && tick) begin
                shift_next = {shift_reg[6:0], i_sdi};
                pend_next = 1'b0;
            end
            if (sck_edge) begin
                edge_cnt_next = 5'(edge_cnt_reg + 5'h01);
                if (out_edge) begin
                    sdo_next = tx_sr_reg[7];
                    tx_sr_next = {tx_sr_reg[6:0], 1'b0};
                end else if (i_sample_phase) begin
                    pend_next = 1'b1;
                end else begin
                    shift_next = {shift_reg[6:0], i_sdi};
                end
            end
            if ((edge_cnt_reg == SSP_SPI_EDGES) && !pend_reg) begin
                spi_busy_next = 1'b0;
                spi_done = 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            spi_busy_reg <= 1'b0;
            sck_reg <= 1'b0;
            tgl_cnt_reg <= 5'h00;
            edge_cnt_reg <= 5'h00;
            tx_sr_reg <= 8'h00;
            sdo_reg <= 1'b0;
            shift_reg <= 8'h00;
            pend_reg <= 1'b0;
        end else begin
            spi_busy_reg <= spi_busy_next;
            sck_reg <= sck_next;
            tgl_cnt_reg <= tgl_cnt_next;
            edge_cnt_reg <= edge_cnt_next;
            tx_sr_reg <= tx_sr_next;
            sdo_reg <= sdo_next;
            shift_reg <= shift_next;
            pend_reg <= pend_next;
        end
    end

    // Bus slave receive sequence
    always_comb begin
        i2c_st_next = i2c_st_reg;
        bit_cnt_next = bit_cnt_reg;
        i2c_sr_next = i2c_sr_reg;
        sda_oe_next = sda_oe_reg;
        start_ev = 1'b0;
        stop_ev = 1'b0;
        i2c_accept = 1'b0;
        i2c_ovf = 1'b0;
        hold_set = 1'b0;
        rw_load = 1'b0;
        match = 1'b0;
        room = ~(bf_reg | ov_reg) | i_buffer_overwrite_en;
        if (!i2c_active) begin
            i2c_st_next = SSP_I2C_IDLE;
            sda_oe_next = 1'b0;
        end else if (sda_fall && scl_level && i_scl) begin
            start_ev = 1'b1;
            i2c_st_next = SSP_I2C_ADDR;
            bit_cnt_next = 4'h0;
            sda_oe_next = 1'b0;
        end else if (sda_rise && scl_level && i_scl) begin
            stop_ev = 1'b1;
            i2c_st_next = SSP_I2C_IDLE;
            sda_oe_next = 1'b0;
        end else begin
            case (i2c_st_reg)
                SSP_I2C_ADDR, SSP_I2C_DATA: begin
                    if (scl_rise && (bit_cnt_reg < SSP_I2C_BITS)) begin
                        i2c_sr_next = {i2c_sr_reg[6:0], i_sda};
                        bit_cnt_next = 4'(bit_cnt_reg + 4'h1);
                    end
                    if (scl_fall && (bit_cnt_reg == SSP_I2C_BITS)) begin
                        if (i2c_st_reg == SSP_I2C_ADDR) begin
                            rw_load = 1'b1;
                            match = (i2c_sr_reg[7:1] == i_slave_addr) && !i2c_sr_reg[0];
                        end else begin
                            match = 1'b1;
                        end
                        i2c_ovf = match & bf_reg;
                        if (match && room) begin
                            sda_oe_next = 1'b1;
                            i2c_accept = 1'b1;
                            i2c_st_next = SSP_I2C_ACK;
                        end else begin
                            i2c_st_next = SSP_I2C_SKIP;
                        end
                    end
                end
                SSP_I2C_ACK: begin
                    if (scl_fall) begin
                        sda_oe_next = 1'b0;
                        bit_cnt_next = 4'h0;
                        hold_set = i_stretch_enable;
                        i2c_st_next = SSP_I2C_DATA;
                    end
                end
                SSP_I2C_IDLE, SSP_I2C_SKIP: sda_oe_next = 1'b0;
                default: begin
                    i2c_st_next = SSP_I2C_IDLE;
                    sda_oe_next = 1'b0;
                end
            endcase
        end
        // A new stretch wins over a release in the same cycle
        hold_next = hold_set | (hold_reg & i2c_active & ~stop_ev & ~i_clk_release_set);
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            i2c_st_reg <= SSP_I2C_IDLE;
            bit_cnt_reg <= 4'h0;
            i2c_sr_reg <= 8'h00;
            sda_oe_reg <= 1'b0;
            hold_reg <= 1'b0;
        end else begin
            i2c_st_reg <= i2c_st_next;
            bit_cnt_reg <= bit_cnt_next;
            i2c_sr_reg <= i2c_sr_next;
            sda_oe_reg <= sda_oe_next;
            hold_reg <= hold_next;
        end
    end

    // Buffer and flags; every hardware set wins over a software clear
    always_comb begin
        ov_set = i2c_ovf | (spi_done & bf_reg);
        irq_set = spi_done | i2c_accept | (start_ev & i_start_irq_en);
        buf_next = (spi_done && !bf_reg) ? shift_reg : (i2c_accept ? i2c_sr_reg : buf_reg);
        bf_next = ((spi_done && !bf_reg) || i2c_accept) ? 1'b1 : (i_buf_rd ? 1'b0 : bf_reg);
        ov_next = ov_set ? 1'b1 : (i_overflow_clr ? 1'b0 : ov_reg);
        irq_next = irq_set ? 1'b1 : (i_irq_flag_clr ? 1'b0 : irq_reg);
        start_next = start_ev ? 1'b1 : (stop_ev ? 1'b0 : start_reg);
        stop_next = stop_ev ? 1'b1 : (start_ev ? 1'b0 : stop_reg);
        rw_next = rw_load ? i2c_sr_reg[0] : rw_reg;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            buf_reg <= SSP_BUF_RST;
            bf_reg <= 1'b0;
            ov_reg <= 1'b0;
            irq_reg <= 1'b0;
            start_reg <= 1'b0;
            stop_reg <= 1'b0;
            rw_reg <= SSP_RW_RST;
        end else begin
            buf_reg <= buf_next;
            bf_reg <= bf_next;
            ov_reg <= ov_next;
            irq_reg <= irq_next;
            start_reg <= start_next;
            stop_reg <= stop_next;
            rw_reg <= rw_next;
        end
    end

    assign o_xfer_buffer = buf_reg;
    assign o_buffer_full = bf_reg;
    assign o_rx_overflow = ov_reg;
    assign o_port_irq_flag = irq_reg;
    assign o_start_seen = start_reg;
    assign o_stop_seen = stop_reg;
    assign o_rw_status = rw_reg;
    assign o_spi_busy = spi_busy_reg;
    assign o_clk_held = hold_reg;

    assign o_sck = sck_reg;
    assign o_sck_oe = spi_mode;
    assign o_sdo = sdo_reg;
    assign o_sdo_oe = spi_mode & ~i_sdo_disable;
    // Open drain: only ever pull low; the external master waits on a held clock
    assign o_scl_out = 1'b0;
    assign o_scl_oe = hold_reg;
    assign o_sda_out = 1'b0;
    assign o_sda_oe = sda_oe_reg;
    assign o_pin_override = i2c_active;

endmodule : ssp_serial_port

//--- tb/ssp_port_sva.sv
// Checker on the serial port top-level ports, attached by bind
// Assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
module ssp_port_sva (
    // Clock, reset and controls
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_enable,
    input wire logic i_mode_i2c,
    input wire logic i_clk_polarity_release,
    input wire logic i_buf_wr,
    input wire logic i_buf_rd,
    input wire logic i_clk_release_set,
    input wire logic i_irq_flag_clr,
    // Bus lines
    input wire logic i_scl,
    input wire logic i_sda,
    // Watched outputs
    input wire logic o_buffer_full,
    input wire logic o_port_irq_flag,
    input wire logic o_start_seen,
    input wire logic o_stop_seen,
    input wire logic o_spi_busy,
    input wire logic o_sck,
    input wire logic o_sck_oe,
    input wire logic o_scl_oe,
    input wire logic o_sda_oe,
    input wire logic o_pin_override
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_srst);

    logic spi_on;
    logic bus_on;
    assign spi_on = i_enable && !i_mode_i2c;
    assign bus_on = i_enable && i_mode_i2c;

    sequence seq_start;
        bus_on && i_scl && $past(i_scl) && $past(i_sda) && !i_sda;
    endsequence
    sequence seq_stop;
        bus_on && i_scl && $past(i_scl) && !$past(i_sda) && i_sda;
    endsequence
    // Idle long enough that the clock pin must sit at the polarity level
    sequence seq_spi_quiet;
        spi_on && $past(spi_on, 2) && !o_spi_busy && $stable(o_spi_busy) && $stable(i_clk_polarity_release)
            && !$past(i_srst);
    endsequence

    AST_SCK_OE: assert property (o_sck_oe == spi_on)
        else $error("clock enable wrong for mode");
    AST_PIN_OVR: assert property (bus_on |-> o_pin_override)
        else $error("pin direction not taken over");
    AST_SPI_GO: assert property (spi_on && i_buf_wr && !o_spi_busy |=> o_spi_busy)
        else $error("write did not start transfer");
    AST_SPI_IDLE: assert property (seq_spi_quiet |-> o_sck == i_clk_polarity_release)
        else $error("idle clock level wrong");
    AST_SPI_DONE: assert property ($fell(o_spi_busy) |-> o_port_irq_flag && o_buffer_full)
        else $error("byte end without flags");
    AST_IRQ_KEEP: assert property (o_port_irq_flag && !i_irq_flag_clr |=> o_port_irq_flag)
        else $error("flag cleared by hardware");
    AST_FULL_CLR: assert property ($fell(o_buffer_full) |-> $past(i_buf_rd))
        else $error("full dropped without read");
    AST_HOLD_REL: assert property (o_scl_oe && i_clk_release_set |=> !o_scl_oe)
        else $error("clock not released");
    AST_ACK_FLAGS: assert property ($rose(o_sda_oe) |-> o_buffer_full && o_port_irq_flag)
        else $error("ack without flags");
    AST_START: assert property (seq_start |-> ##[1:3] (o_start_seen && !o_stop_seen))
        else $error("start not flagged");
    AST_STOP: assert property (seq_stop |-> ##[1:3] (o_stop_seen && !o_start_seen))
        else $error("stop not flagged");
endmodule : ssp_port_sva

bind ssp_serial_port ssp_port_sva u_ssp_port_sva (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_enable(i_enable), .i_mode_i2c(i_mode_i2c),
    .i_clk_polarity_release(i_clk_polarity_release), .i_buf_wr(i_buf_wr), .i_buf_rd(i_buf_rd),
    .i_clk_release_set(i_clk_release_set), .i_irq_flag_clr(i_irq_flag_clr), .i_scl(i_scl), .i_sda(i_sda),
    .o_buffer_full(o_buffer_full), .o_port_irq_flag(o_port_irq_flag), .o_start_seen(o_start_seen),
    .o_stop_seen(o_stop_seen), .o_spi_busy(o_spi_busy), .o_sck(o_sck), .o_sck_oe(o_sck_oe),
    .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe), .o_pin_override(o_pin_override)
);

//--- tb/ssp_far_model.sv
// Far side: clocked serial slave and two-wire bus master
// Assumes the bench resolves the open-drain bus with pull-ups
`timescale 1ns/1ps
module ssp_far_model (
    // Clock
    input wire logic i_ref_clk,
    // Clocked serial pins
    input wire logic i_sck,
    input wire logic i_sdo,
    output logic o_sdi,
    // Bus lines
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    logic [7:0] tx_reg = 8'h00;
    logic [7:0] rx_reg = 8'h00;
    int stalls = 0;

    // Past the last bit the line keeps changing, never a stale copy
    assign o_sdi = tx_reg[7];
    always @(posedge i_sck) rx_reg <= {rx_reg[6:0], i_sdo};
    always @(negedge i_sck) tx_reg <= {tx_reg[6:0], ~tx_reg[0]};

    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : wait_clk

    task automatic scl_pulse(output logic sample_phase);
        int k;
        wait_clk(2);
        o_scl = 1'b1;
        k = 0;
        while (i_scl !== 1'b1 && k < 300) begin
            wait_clk(1);
            k++;
        end
        if (k == 300) stalls++;
        wait_clk(2);
        sample_phase = i_sda;
        o_scl = 1'b0;
    endtask : scl_pulse

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            o_sda = b[i];
            scl_pulse(s);
        end
        o_sda = 1'b1;
        scl_pulse(s);
        ack = ~s;
    endtask : send_byte

    task automatic start_cond();
        o_sda = 1'b1;
        wait_clk(2);
        o_scl = 1'b1;
        wait_clk(2);
        o_sda = 1'b0;
        wait_clk(2);
        o_scl = 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        o_sda = 1'b0;
        wait_clk(2);
        o_scl = 1'b1;
        wait_clk(2);
        o_sda = 1'b1;
        wait_clk(2);
    endtask : stop_cond
endmodule : ssp_far_model

//--- tb/ssp_serial_port_tb.sv
// Bench for the serial port: master transfers, then bus slave receive
// Assumes the far-side model and the bound checker are compiled alongside
`timescale 1ns/1ps
module ssp_serial_port_tb;
    import ssp_pkg::*;
    localparam logic [6:0] ADDR = 7'h5A;
    localparam int HALF [5] = '{SSP_HALF_DIV4, SSP_HALF_DIV16, SSP_HALF_DIV64, 0, 2 * SSP_HALF_BAUD_STEP};
    logic clk = 1'b0, rst = 1'b1, en = 1'b0, i2c = 1'b0, pol = 1'b0, sample_phase = 1'b0, t2 = 1'b0;
    logic [2:0] rate = 3'h0;
    logic [7:0] wdata = 8'h00, buf_q;
    logic sdo_dis = 1'b0, sten = 1'b0, buffer_overwrite_en = 1'b0, sirq = 1'b0;
    logic wr = 1'b0, rd = 1'b0, rel = 1'b0, ovc = 1'b0, irqc = 1'b0;
    logic full, ovf, irq, sts, stp, rw, busy, held, sck, sck_oe, sdo, sdo_oe, sdi;
    logic scl_out, scl_oe, sda_out, sda_oe, ovr, m_scl, m_sda, ack;
    wire logic scl = m_scl & (~scl_oe | scl_out);
    wire logic sda = m_sda & (~sda_oe | sda_out);
    int failures = 0;
    int checks = 0;

    ssp_serial_port u_ssp_serial_port (
        .i_ref_clk(clk), .i_srst(rst), .i_enable(en), .i_mode_i2c(i2c), .i_clk_polarity_release(pol),
        .i_clk_edge_sel(1'b1), .i_sample_phase(sample_phase), .i_rate_sel(rate), .i_baud_reload(8'h01),
        .i_timer2_tick(t2), .i_sdo_disable(sdo_dis), .i_slave_addr(ADDR), .i_stretch_enable(sten),
        .i_buffer_overwrite_en(buffer_overwrite_en), .i_start_irq_en(sirq), .i_buf_wr(wr), .i_buf_wdata(wdata),
        .i_buf_rd(rd), .i_clk_release_set(rel), .i_overflow_clr(ovc), .i_irq_flag_clr(irqc),
        .o_xfer_buffer(buf_q), .o_buffer_full(full), .o_rx_overflow(ovf), .o_port_irq_flag(irq),
        .o_start_seen(sts), .o_stop_seen(stp), .o_rw_status(rw), .o_spi_busy(busy), .o_clk_held(held),
        .o_sck(sck), .o_sck_oe(sck_oe), .i_sck_in(sck), .o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_sdi(sdi),
        .i_scl(scl), .i_sda(sda), .o_scl_out(scl_out), .o_scl_oe(scl_oe), .o_sda_out(sda_out),
        .o_sda_oe(sda_oe), .o_pin_override(ovr)
    );
    ssp_far_model u_far (.i_ref_clk(clk), .i_sck(sck), .i_sdo(sdo), .o_sdi(sdi), .i_scl(scl), .i_sda(sda),
        .o_scl(m_scl), .o_sda(m_sda));

    initial forever #50 clk = ~clk;
    initial forever begin
        repeat (3) @(posedge clk);
        #1 t2 = 1'b1;
        @(posedge clk);
        #1 t2 = 1'b0;
    end

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick

    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask : pulse

    // Starts a master byte and counts busy cycles and clock pin changes
    task automatic spi_xfer(input logic [7:0] d, input logic [7:0] rxv, output int cyc, output int edges);
        logic last;
        u_far.tx_reg = rxv;
        wdata = d;
        pulse(wr);
        chk("first bit", {15'h0, d[7]}, sdo);
        cyc = 0;
        edges = 0;
        last = sck;
        while (busy === 1'b1 && cyc < 3000) begin
            tick(1);
            cyc++;
            if (sck !== last) edges++;
            last = sck;
        end
        if (cyc >= 3000) begin
            failures++;
            tally_and_finish();
        end
        tick(1);
    endtask : spi_xfer

    initial begin
        int cyc;
        int edges;
        tick(12);
        rst = 1'b0;
        chk("buffer at reset", SSP_BUF_RST, buf_q);
        chk("flags at reset", 16'h0, {full, ovf, irq, sts, stp, rw, busy, held});
        en = 1'b1;
        for (int r = 0; r < 5; r++) begin
            rate = r[2:0];
            sample_phase = (r == 2);
            sdo_dis = (r == 4);
            spi_xfer(8'hA5 ^ r[7:0], 8'h3C + r[7:0], cyc, edges);
            chk("sck edges", 16'h10, edges[15:0]);
            if (HALF[r] != 0) chk("busy span", 16'h1, {15'h0, cyc >= 15 * HALF[r] && cyc <= 17 * HALF[r] + 2});
            chk("rx byte", 8'h3C + r[7:0], buf_q);
            if (r < 4) chk("tx byte", 8'hA5 ^ r[7:0], u_far.rx_reg);
            chk("sdo enable", {15'h0, r != 4}, sdo_oe);
            chk("full irq", 16'h3, {full, irq});
            pulse(rd);
            pulse(irqc);
            chk("full after read", 16'h0, full);
        end
        rate = SSP_RATE_DIV4;
        sdo_dis = 1'b0;
        spi_xfer(8'h81, 8'h5E, cyc, edges);
        spi_xfer(8'hC3, 8'h99, cyc, edges);
        chk("kept on overflow", 16'h035E, {6'h0, ovf, full, buf_q});
        chk("tx second", 8'hC3, u_far.rx_reg);
        pulse(rd);
        pulse(ovc);
        pulse(irqc);
        pol = 1'b1;
        tick(4);
        chk("idle high", 16'h1, sck);
        i2c = 1'b1;
        sten = 1'b1;
        sirq = 1'b1;
        tick(2);
        chk("pin override", 16'h1, ovr);
        u_far.start_cond();
        tick(3);
        chk("start flags", 16'h5, {sts, stp, irq});
        pulse(irqc);
        u_far.send_byte({ADDR, 1'b0}, ack);
        tick(3);
        chk("addr ack", 16'h1, ack);
        chk("addr byte", {ADDR, 1'b0}, buf_q);
        chk("full irq rw held", 16'h1B, {full, irq, rw, scl_oe, held});
        pulse(rd);
        pulse(irqc);
        chk("full after addr", 16'h0, full);
        fork
            u_far.send_byte(8'h3C, ack);
            begin
                tick(30);
                chk("held", 16'h1, scl_oe);
                pulse(rel);
            end
        join
        tick(3);
        chk("data ack byte", 16'h013C, {7'h0, ack, buf_q});
        chk("data flags", 16'h7, {full, irq, scl_oe});
        pulse(rel);
        u_far.stop_cond();
        tick(3);
        chk("stop flags", 16'h1, {sts, stp});
        for (int k = 0; k < 2; k++) begin
            buffer_overwrite_en = k[0];
            u_far.start_cond();
            u_far.send_byte({ADDR, 1'b0}, ack);
            tick(3);
            chk("ack when full", {15'h0, k[0]}, ack);
            chk("overflow", 16'h1, ovf);
            if (k == 1) pulse(rel);
            u_far.stop_cond();
        end
        chk("bus stalls", 16'h0, u_far.stalls[15:0]);
        tally_and_finish();
    end
endmodule : ssp_serial_port_tb
